// *** hdl/gp8_port.sv ***
// Eight-line general-purpose port, AHB-Lite slave
`timescale 1ns/1ns
`include "gpio8_defs.svh"
module gp8_port
	import gp8_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Port lines
	input wire logic [7:0] gpio_in,
	output logic [7:0] gpio_out,
	output logic [7:0] gpio_oe
);

	gp8_phase_t phase_ff;
	logic [7:0] out_ff;
	logic [7:0] dir_ff;
	logic [31:0] rdata_ff;
	gp8_drive_t drive_ff;
	gp8_drive_t nxt_drive;
	logic [7:0] pin_level;
	logic [7:0] nxt_out;
	logic [31:0] nxt_rdata;
	logic ready_ff;
	logic resp_ff;

	// Address decode; aliases in the 16 MB window are ignored, true address only
	function automatic gp8_sel_t decode(input logic [31:0] addr);
		case (addr)
			`GP8_ADDR_SET_IN: decode = GP8_SEL_SET_IN;
			`GP8_ADDR_CLR_OUT: decode = GP8_SEL_CLR_OUT;
			`GP8_ADDR_DIR: decode = GP8_SEL_DIR;
			default: decode = GP8_SEL_NONE;
		endcase
	endfunction

	// Pin levels pass the three-stage synchroniser before software sees them
	gp8_pin_sync u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.pin_raw(gpio_in),
		.pin_level(pin_level)
	);

	// Capture the address phase of every valid transfer
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			phase_ff <= '0;
		end else if (hready) begin
			phase_ff.active <= hsel & htrans[1];
			phase_ff.write <= hwrite;
			phase_ff.sel <= decode(haddr);
		end
	end

	// Output register update from set and clear locations
	always_comb begin
		nxt_out = out_ff;
		if (phase_ff.active && phase_ff.write) begin
			if (phase_ff.sel == GP8_SEL_SET_IN) begin
				nxt_out = out_ff | hwdata[7:0];
			end else if (phase_ff.sel == GP8_SEL_CLR_OUT) begin
				nxt_out = out_ff & ~hwdata[7:0];
			end
		end
	end

	// Output data register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			out_ff <= `GP8_OUT_RESET;
		end else begin
			out_ff <= nxt_out;
		end
	end

	// Direction register; only bits 7..4 are stored, lower bits read zero
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			dir_ff <= `GP8_DIR_RESET;
		end else if (phase_ff.active && phase_ff.write && phase_ff.sel == GP8_SEL_DIR) begin
			dir_ff <= hwdata[7:0] & ~`GP8_FIXED_OUT_MASK;
		end
	end

	// Read data sampled in the address phase for its data phase; registered so hrdata is a flop
	always_comb begin
		nxt_rdata = 32'h00000000;
		if (hready && hsel && htrans[1] && !hwrite) begin
			case (decode(haddr))
				GP8_SEL_SET_IN: nxt_rdata = {24'h000000, pin_level};
				GP8_SEL_CLR_OUT: nxt_rdata = {24'h000000, nxt_out};
				GP8_SEL_DIR: nxt_rdata = {24'h000000, dir_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end else if (!hready) begin
			nxt_rdata = rdata_ff;
		end
	end

	// Read data register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Pin drive: low nibble always driven, high nibble gated by direction
	always_comb begin
		nxt_drive.level = nxt_out;
		nxt_drive.enable = `GP8_FIXED_OUT_MASK | dir_ff;
		if (phase_ff.active && phase_ff.write && phase_ff.sel == GP8_SEL_DIR) begin
			nxt_drive.enable = `GP8_FIXED_OUT_MASK | (hwdata[7:0] & ~`GP8_FIXED_OUT_MASK);
		end
	end

	// Registered pin drivers
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			drive_ff.level <= `GP8_OUT_RESET;
			drive_ff.enable <= `GP8_FIXED_OUT_MASK;
		end else begin
			drive_ff <= nxt_drive;
		end
	end

	// Zero-wait slave held in flops so every output leaves a register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ready_ff <= 1'b1;
			resp_ff <= 1'b0;
		end else begin
			ready_ff <= 1'b1;
			resp_ff <= 1'b0;
		end
	end

	// Unmapped addresses read zero and ignore writes
	assign hreadyout = ready_ff;
	assign hresp = resp_ff;
	assign hrdata = rdata_ff;
	assign gpio_out = drive_ff.level;
	assign gpio_oe = drive_ff.enable;

endmodule

// *** hdl/gpio8_defs.svh ***
// Register offsets, field positions and reset values of the eight-line port
`ifndef GPIO8_DEFS_SVH
`define GPIO8_DEFS_SVH

`define GP8_ADDR_SET_IN 32'hC9000000
`define GP8_ADDR_CLR_OUT 32'hC9000004
`define GP8_ADDR_DIR 32'hC9000008
`define GP8_WIDTH 8
`define GP8_CFG_LO 4
`define GP8_DIR_RESET 8'h00
`define GP8_OUT_RESET 8'h00
`define GP8_FIXED_OUT_MASK 8'h0F

`endif

// *** hdl/gp8_pkg.sv ***
// Types shared by the eight-line port design
package gp8_pkg;

	// Decoded register selection captured in the address phase
	typedef enum logic [1:0] {
		GP8_SEL_NONE = 2'b00,
		GP8_SEL_SET_IN = 2'b01,
		GP8_SEL_CLR_OUT = 2'b10,
		GP8_SEL_DIR = 2'b11
	} gp8_sel_t;

	// Pending AHB-Lite data phase
	typedef struct packed {
		logic active;
		logic write;
		gp8_sel_t sel;
	} gp8_phase_t;

	// Pin drive bundle
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] enable;
	} gp8_drive_t;

endpackage

// *** hdl/gp8_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter for the port inputs
`timescale 1ns/1ns
`include "gpio8_defs.svh"
module gp8_pin_sync
	import gp8_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Raw and filtered levels
	input wire logic [7:0] pin_raw,
	output logic [7:0] pin_level
);

	logic [7:0] stage1_ff;
	logic [7:0] stage2_ff;
	logic [7:0] stage3_ff;
	logic [7:0] level_ff;

	// Shift chain; the first stage is read only by the second
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			stage1_ff <= 8'h00;
			stage2_ff <= 8'h00;
			stage3_ff <= 8'h00;
		end else begin
			stage1_ff <= pin_raw;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// A change counts only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_agree
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					level_ff[i] <= 1'b0;
				end else if (stage2_ff[i] == stage3_ff[i]) begin
					level_ff[i] <= stage3_ff[i];
				end
			end
		end
	endgenerate

	assign pin_level = level_ff;

endmodule

// *** testbench/gp8_pins_model.sv ***
// Connector lines: pull-ups plus optional external drivers
`timescale 1ns/1ns
module gp8_pins_model(
	// Port and external drive
	input wire logic [7:0] gpio_out,
	input wire logic [7:0] gpio_oe,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	// Line levels
	output logic [7:0] pin
);
	// Port drive wins; an undriven line floats high on its pull-up
	assign pin = gpio_oe & gpio_out | ~gpio_oe & (ext_en & ext_val | ~ext_en);
endmodule

// *** testbench/gp8_port_monitor.sv ***
// Checker for the port bus and line behaviour
`timescale 1ns/1ns
`include "gpio8_defs.svh"
module gp8_port_monitor(
	// Clock, reset and bus
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Lines
	input wire logic [7:0] gpio_out,
	input wire logic [7:0] gpio_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic ap;
	// Selected address phase
	assign ap = hsel && hready && htrans[1];
	bus_ok_a: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0) else $error("bus");
	low_drive_a: assert property (gpio_oe[3:0] == 4'hF) else $error("low oe");
	set_bits_a: assert property (ap && hwrite && haddr == `GP8_ADDR_SET_IN ##1 1
		|=> gpio_out == ($past(gpio_out) | $past(hwdata[7:0]))) else $error("set");
	clr_bits_a: assert property (ap && hwrite && haddr == `GP8_ADDR_CLR_OUT ##1 1
		|=> gpio_out == ($past(gpio_out) & ~$past(hwdata[7:0]))) else $error("clr");
	out_read_a: assert property (ap && !hwrite && haddr == `GP8_ADDR_CLR_OUT |=> hrdata[7:0] == gpio_out)
		else $error("out rd");
	dir_oe_a: assert property (ap && hwrite && haddr == `GP8_ADDR_DIR ##1 1
		|=> gpio_oe[7:4] == $past(hwdata[7:4])) else $error("dir");
	dir_reset_a: assert property ($rose(reset_n) |-> gpio_oe[7:4] == 4'h0) else $error("dir rst");
	oe_hold_a: assert property (!$past(ap && hwrite) |=> $stable(gpio_oe)) else $error("oe");
endmodule
bind gp8_port gp8_port_monitor mon(.*);

// *** testbench/eight_bit_io_port_bench.sv ***
// Bench for the eight-line port
`timescale 1ns/1ns
`include "gpio8_defs.svh"
module eight_bit_io_port_bench;
	logic core_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, hready = 1, hreadyout, hresp;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [7:0] gpio_in, gpio_out, gpio_oe, ext_val = 0, ext_en = 0;
	int bad_count = 0, tests_run = 0;
	localparam logic [31:0] AS = `GP8_ADDR_SET_IN, AC = `GP8_ADDR_CLR_OUT, AD = `GP8_ADDR_DIR;
	// Clock
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	gp8_port uut(.*);
	gp8_pins_model pins(.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_val(ext_val), .ext_en(ext_en), .pin(gpio_in));
	task chk(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// Address phase, then data phase; read data is checked mid data phase
	task bus(input logic wr, input logic [31:0] a, d);
		@(negedge core_clk);
		{hsel, htrans, hwrite, haddr} = {1'b1, 2'h2, wr, a};
		@(negedge core_clk);
		{hsel, htrans, hwdata} = {1'b0, 2'h0, d};
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#100000;
		bad_count++;
		wrap_up;
	end
	initial begin
		repeat (3) @(negedge core_clk);
		reset_n = 1;
		chk(gpio_oe, 32'h0F);
		bus(0, AD, 0);
		chk(hrdata, 32'h0);
		chk({hreadyout, hresp}, 32'h2);
		bus(1, AS, 32'hA5);
		bus(0, AC, 0);
		chk(hrdata, 32'hA5);
		bus(1, AC, 32'h0F);
		bus(0, AC, 0);
		chk(hrdata, 32'hA0);
		chk(gpio_out, 32'hA0);
		bus(1, AD, 32'hF0);
		bus(0, AD, 0);
		chk(hrdata, 32'hF0);
		chk(gpio_oe, 32'hFF);
		repeat (6) @(negedge core_clk);
		bus(0, AS, 0);
		chk(hrdata, 32'hA0);
		bus(1, AD, 32'h30);
		{ext_val, ext_en} = 16'h40C0;
		@(negedge core_clk);
		chk(gpio_oe, 32'h3F);
		repeat (6) @(negedge core_clk);
		bus(0, AS, 0);
		chk(hrdata, 32'h60);
		bus(1, AD + 4, 32'hFF);
		bus(0, AD + 4, 0);
		chk(hrdata, 32'h0);
		wrap_up;
	end
endmodule
